// ==== rtl/dpdc_pkg.sv ====
// Package: register map, field widths and timing constants for the dual loop control
package dpdc_pkg;
   // Register byte offsets
   localparam logic [7:0] REG_CTRL      = 8'h00;
   localparam logic [7:0] REG_REFSEL    = 8'h04;
   localparam logic [7:0] REG_STEP_LO   = 8'h08;
   localparam logic [7:0] REG_STEP_HI   = 8'h0C;
   localparam logic [7:0] REG_DCO_CMD   = 8'h10;
   localparam logic [7:0] REG_DEN24_0   = 8'h14;
   localparam logic [7:0] REG_DEN24_1   = 8'h18;
   localparam logic [7:0] REG_STATUS    = 8'h1C;
   localparam logic [7:0] REG_NUM0_LO   = 8'h20;
   localparam logic [7:0] REG_NUM0_HI   = 8'h24;
   localparam logic [7:0] REG_NUM1_LO   = 8'h28;
   localparam logic [7:0] REG_NUM1_HI   = 8'h2C;
   localparam logic [7:0] REG_GAIN      = 8'h30;
   // CTRL field positions
   localparam int CTRL_AEN0    = 0;
   localparam int CTRL_AEN1    = 1;
   localparam int CTRL_DEN0    = 2;
   localparam int CTRL_DEN1    = 3;
   localparam int CTRL_MODE0   = 4;
   localparam int CTRL_MODE1   = 5;
   localparam int CTRL_DCO0    = 6;
   localparam int CTRL_DCO1    = 7;
   localparam int CTRL_PRIO    = 8;
   localparam int CTRL_CASC    = 9;
   localparam int CTRL_POSTDIV = 10;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0033;
   // REFSEL fields: per loop, bit0 cascade select, bit1 preferred input
   localparam int RS_STRIDE = 4;
   // DCO command bits: per loop, bit0 up, bit1 down
   localparam int DCO_STRIDE = 2;
   // Widths
   localparam int FRAC_W = 40;
   localparam int DEN24_W = 24;
   localparam int PHASE_W = 16;
   // Timing in ns and clock cycles; reset values
   localparam int CLK_PERIOD_NS = 10;
   localparam int REF_VALID_NS  = 10000;
   localparam int REF_VALID_CYC = (REF_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CAL_NS        = 2000;
   localparam int CAL_CYC       = (CAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [39:0] CENTER_NUM = 40'h80_0000_0000;
   localparam logic [31:0] DEN24_RESET = 32'h0080_0000;
   localparam logic [3:0] GAIN_RESET = 4'h4;
   // Analog loop states
   typedef enum logic [1:0] {
      ALOOP_OFF  = 2'b00,
      ALOOP_CAL  = 2'b01,
      ALOOP_HOLD = 2'b10,
      ALOOP_FREE = 2'b11
   } dpdc_aloop_t;
   // Digital loop states
   typedef enum logic [1:0] {
      DLOOP_IDLE    = 2'b00,
      DLOOP_QUALIFY = 2'b01,
      DLOOP_FIRST   = 2'b10,
      DLOOP_TRACK   = 2'b11
   } dpdc_dloop_t;
endpackage

// ==== rtl/dpdc_ctrl.sv ====
// Dual digital/analog loop domain control with Avalon-MM register slave
`timescale 1ns/1ps
// How it works
// R1 - Each digital loop: phase comparator, loop filter, 40-bit fractional divider numerator.
// R2 - Digital loop reference mux: cascaded other-domain clock or an external input.
// R3 - Analog loop reference mux: cascaded other-domain clock or crystal input.
// R4 - Software never cascades one oscillator to both references of a pair.
// R5 - Fixed 40-bit denominator steered by digital loop; 24-bit one selectable alone.
// R6 - Post-divider value 1 bypasses divider, oscillator feeds distribution directly.
// R7 - Controlled-oscillator mode steps numerator up or down by programmed step.
// R8 - Software keeps loop bandwidth below comparator/100, analog/10 and 4 kHz.
// R9 - At start each analog loop locks to crystal and free-runs.
// R10 - Digital loop acquires only after valid reference, chosen by priority.
// R11 - Comparator phase error filtered and applied to analog numerator.
// R12 - Two digital loops lock or unlock independently of each other.
// R13 - Cascaded: primary held at center until secondary locks, then free-runs.
// R14 - First correction after qualify cancels error unfiltered; later ones filtered.
// R15 - Software confirms primary lock, toggles secondary enable, rechecks lock.
// R16 - Secondary digital off in cascade: secondary oscillator tracks primary domain.
// R17 - Software uses 24-bit denominator when digital loop disabled.
// R18 - Analog-only mode: analog loops lock in order set by start priority.
// R19 - Denominator mode zero selects 24-bit, one selects fixed 40-bit.
// R20 - Analog-only: digital loops do not touch analog loops; stepping still works.
// R21 - Software powers down unused digital or analog loops.
// R22 - Secondary digital loop drives secondary analog numerator.
// R23 - Loss of reference: switch to another input or enter holdover.
// R24 - Lock indication readable per digital and analog loop.
module dpdc_ctrl #(
   parameter int REF_VALID_CYCLES = dpdc_pkg::REF_VALID_CYC
) (
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic [1:0]  ref_lost,
   input  wire logic [1:0]  aloop_locked_in,
   input  wire logic [31:0] phase_err0,
   input  wire logic [31:0] phase_err1,
   output logic [39:0]      analog_num0,
   output logic [39:0]      analog_num1,
   output logic [1:0]       den_fixed_sel,
   output logic [1:0]       aloop_ref_casc,
   output logic [1:0]       dloop_ref_casc,
   output logic [1:0]       dloop_ref_index,
   output logic             postdiv_bypass
);
   // ref_lost and aloop_locked_in pass two flip-flops before use; phase_err0/1 are used directly
   logic [1:0] lost_s1_q;
   logic [1:0] lost_s2_q;
   logic [1:0] alock_s1_q;
   logic [1:0] alock_s2_q;
   always_ff @(posedge ref_clk) begin
      lost_s1_q  <= ref_lost;
      lost_s2_q  <= lost_s1_q;
      alock_s1_q <= aloop_locked_in;
      alock_s2_q <= alock_s1_q;
   end

   // Software registers
   logic [31:0] ctrl_q;
   logic [31:0] refsel_q;
   logic [39:0] step_q;
   logic [23:0] den0_q;
   logic [23:0] den1_q;
   logic [3:0]  gain_q;
   logic [3:0]  dco_cmd_q;
   logic        ack_q;

   // Byte-enable merge, used for every writable word except REG_GAIN and REG_DCO_CMD
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // One wait cycle per access, so every request answers on the second edge
   wire req = avs_read | avs_write;
   wire wr_go = avs_write & ack_q;
   assign avs_waitrequest = req & ~ack_q;
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end

   wire [31:0] step_lo_w = merge(step_q[31:0], avs_writedata, avs_byteenable);
   wire [31:0] step_hi_w = merge({24'h00_0000, step_q[39:32]}, avs_writedata, avs_byteenable);
   wire [31:0] ctrl_w    = merge(ctrl_q, avs_writedata, avs_byteenable);
   wire [31:0] refsel_w  = merge(refsel_q, avs_writedata, avs_byteenable);
   wire [31:0] den0_w    = merge({8'h00, den0_q}, avs_writedata, avs_byteenable);
   wire [31:0] den1_w    = merge({8'h00, den1_q}, avs_writedata, avs_byteenable);

   // Register writes; DCO command is a one-cycle pulse
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         ctrl_q    <= dpdc_pkg::CTRL_RESET;
         refsel_q  <= 32'h0000_0000;
         step_q    <= 40'h00_0000_0000;
         den0_q    <= dpdc_pkg::DEN24_RESET[23:0];
         den1_q    <= dpdc_pkg::DEN24_RESET[23:0];
         gain_q    <= dpdc_pkg::GAIN_RESET;
         dco_cmd_q <= 4'h0;
      end else begin
         dco_cmd_q <= (wr_go && avs_address == dpdc_pkg::REG_DCO_CMD) ?
                      avs_writedata[3:0] : 4'h0;
         if (wr_go) begin
            unique case (avs_address)
               dpdc_pkg::REG_CTRL:    ctrl_q   <= ctrl_w;
               dpdc_pkg::REG_REFSEL:  refsel_q <= refsel_w;
               dpdc_pkg::REG_STEP_LO: step_q[31:0]  <= step_lo_w;
               dpdc_pkg::REG_STEP_HI: step_q[39:32] <= step_hi_w[7:0];
               dpdc_pkg::REG_DEN24_0: den0_q <= den0_w[23:0];                 // R5
               dpdc_pkg::REG_DEN24_1: den1_q <= den1_w[23:0];
               dpdc_pkg::REG_GAIN:    gain_q <= avs_writedata[3:0];
               default: ;
            endcase
         end
      end
   end

   // Decoded controls
   wire [1:0] aen   = ctrl_q[dpdc_pkg::CTRL_AEN1:dpdc_pkg::CTRL_AEN0];
   wire [1:0] den   = ctrl_q[dpdc_pkg::CTRL_DEN1:dpdc_pkg::CTRL_DEN0];
   wire [1:0] mode  = ctrl_q[dpdc_pkg::CTRL_MODE1:dpdc_pkg::CTRL_MODE0];
   wire [1:0] dco   = ctrl_q[dpdc_pkg::CTRL_DCO1:dpdc_pkg::CTRL_DCO0];
   wire       prio  = ctrl_q[dpdc_pkg::CTRL_PRIO];   // 0: primary first
   wire       casc  = ctrl_q[dpdc_pkg::CTRL_CASC];   // secondary analog fed from primary
   wire [3:0] pdiv  = ctrl_q[dpdc_pkg::CTRL_POSTDIV +: 4];

   // Per-loop state
   dpdc_pkg::dpdc_aloop_t aq [2];
   dpdc_pkg::dpdc_dloop_t dq [2];
   logic [15:0] cnt_q [2];
   logic [39:0] num_q [2];
   logic [1:0]  sel_q;
   // Comparator words, one per loop
   wire  [31:0] perr [2];
   assign perr[0] = phase_err0;
   assign perr[1] = phase_err1;

   // Loop filter scaling: shift the sign-extended error by the gain setting
   function automatic logic [39:0] filt(input logic [31:0] e, input logic [3:0] g);
      logic [39:0] x;
      x = {{8{e[31]}}, e};
      return $signed(x) >>> g;
   endfunction

   genvar k;
   generate
      for (k = 0; k < 2; k++) begin : g_loop
         // Start order: the lower-priority loop waits for the other to lock or be held at centre
         // Priority bit names the loop that starts first
         wire first = (k == 1);
         // Held at centre counts as settled, else cascade start deadlocks
         wire peer_settled = (aq[1-k] == dpdc_pkg::ALOOP_FREE) |
                             (aq[1-k] == dpdc_pkg::ALOOP_HOLD);
         wire my_turn = (prio == first) | peer_settled | ~aen[1-k];         // R18

         // Cascaded: primary held at center until secondary locks
         wire hold_center = (k == 0) & casc & aen[1] & ~alock_s2_q[1];      // R13
         wire ref_ok = ~lost_s2_q[sel_q[k]];                                // R23
         wire alt_ok = ~lost_s2_q[~sel_q[k]];

         // Preferred input, and whether it or the other is usable
         wire pref        = refsel_q[k*dpdc_pkg::RS_STRIDE + 1];
         wire pref_ok     = ~lost_s2_q[pref];
         wire pref_alt_ok = ~lost_s2_q[~pref];

         wire steer = den[k] & (dq[k] == dpdc_pkg::DLOOP_TRACK ||
                                dq[k] == dpdc_pkg::DLOOP_FIRST);            // R20
         wire up   = dco[k] & dco_cmd_q[k*dpdc_pkg::DCO_STRIDE];
         wire down = dco[k] & dco_cmd_q[k*dpdc_pkg::DCO_STRIDE + 1];

         // Analog loop sequence
         always_ff @(posedge ref_clk) begin
            if (!rst_b || !aen[k]) begin
               aq[k] <= dpdc_pkg::ALOOP_OFF;                                // R15
            end else begin
               unique case (aq[k])
                  // Off until the start order allows calibration
                  dpdc_pkg::ALOOP_OFF:  if (my_turn) aq[k] <= dpdc_pkg::ALOOP_CAL;
                  dpdc_pkg::ALOOP_CAL:  if (alock_s2_q[k] && !hold_center)
                                           aq[k] <= dpdc_pkg::ALOOP_FREE;   // R9
                                        else if (hold_center)
                                           aq[k] <= dpdc_pkg::ALOOP_HOLD;
                  dpdc_pkg::ALOOP_HOLD: if (!hold_center) aq[k] <= dpdc_pkg::ALOOP_CAL;
                  dpdc_pkg::ALOOP_FREE: if (!alock_s2_q[k]) aq[k] <= dpdc_pkg::ALOOP_CAL;
               endcase
            end
         end

         // Digital loop: qualify, unfiltered first word, then filtered
         always_ff @(posedge ref_clk) begin
            if (!rst_b || !den[k] || aq[k] != dpdc_pkg::ALOOP_FREE) begin
               dq[k]    <= dpdc_pkg::DLOOP_IDLE;                            // R12
               cnt_q[k] <= 16'h0000;
               sel_q[k] <= refsel_q[k*dpdc_pkg::RS_STRIDE + 1];
            end else begin
               unique case (dq[k])
                  dpdc_pkg::DLOOP_IDLE: begin
                     // Preferred input if valid, else the other if that is valid
                     sel_q[k] <= (pref_ok || !pref_alt_ok) ? pref : ~pref;  // R10
                     cnt_q[k] <= 16'h0000;
                     if (pref_ok || pref_alt_ok) dq[k] <= dpdc_pkg::DLOOP_QUALIFY; // R10
                  end
                  // Loss of the selected input during qualification restarts the search
                  dpdc_pkg::DLOOP_QUALIFY: begin
                     cnt_q[k] <= cnt_q[k] + 16'h0001;
                     if (!ref_ok) dq[k] <= dpdc_pkg::DLOOP_IDLE;
                     else if (32'(cnt_q[k]) >= REF_VALID_CYCLES - 1)
                        dq[k] <= dpdc_pkg::DLOOP_FIRST;                     // R14
                  end
                  dpdc_pkg::DLOOP_FIRST: dq[k] <= dpdc_pkg::DLOOP_TRACK;
                  // Lost input: hop to the other, else holdover
                  dpdc_pkg::DLOOP_TRACK: begin
                     if (!ref_ok && alt_ok) sel_q[k] <= ~sel_q[k];          // R23
                     else if (!ref_ok) dq[k] <= dpdc_pkg::DLOOP_IDLE;       // R23
                  end
               endcase
            end
         end

         // Numerator: phase correction, stepping, holdover keeps last value
         always_ff @(posedge ref_clk) begin
            if (!rst_b || aq[k] != dpdc_pkg::ALOOP_FREE) begin
               num_q[k] <= dpdc_pkg::CENTER_NUM;                            // R13
            end else if (steer && dq[k] == dpdc_pkg::DLOOP_FIRST) begin
               num_q[k] <= num_q[k] + {{8{perr[k][31]}}, perr[k]};          // R14
            end else if (steer && dq[k] == dpdc_pkg::DLOOP_TRACK && ref_ok) begin
               num_q[k] <= num_q[k] + filt(perr[k], gain_q);                // R11
            end else if (up) begin
               num_q[k] <= num_q[k] + step_q;                               // R7
            end else if (down) begin
               num_q[k] <= num_q[k] - step_q;                               // R7
            end
         end
      end
   endgenerate

   // In cascade, secondary oscillator follows primary numerator when its digital loop is off and the primary's is on
   wire follow = casc & den[0] & ~den[1];                                   // R16
   assign analog_num0 = num_q[0];                                           // R1
   assign analog_num1 = follow ? num_q[0] : num_q[1];                       // R22
   assign den_fixed_sel = mode;                                             // R19
   assign aloop_ref_casc = {casc, refsel_q[0]};                             // R3

   // Primary digital cascade on spare bit 2; bit 0 stays analog only
   assign dloop_ref_casc = {refsel_q[dpdc_pkg::RS_STRIDE],
                            refsel_q[2]};                                   // R2
   assign dloop_ref_index = sel_q;                                          // R2
   assign postdiv_bypass = (pdiv == 4'h1);                                  // R6

   // Status: lock per loop and state codes
   wire [31:0] status_w = {16'h0000, 2'b00, dq[1], dq[0], 2'b00, aq[1], aq[0],
                           (dq[1] == dpdc_pkg::DLOOP_TRACK), (dq[0] == dpdc_pkg::DLOOP_TRACK),
                           (aq[1] == dpdc_pkg::ALOOP_FREE), (aq[0] == dpdc_pkg::ALOOP_FREE)};

   // Read mux; unknown offsets give zero
   wire [31:0] rmux_w =
      (avs_address == dpdc_pkg::REG_CTRL)    ? ctrl_q :
      (avs_address == dpdc_pkg::REG_REFSEL)  ? refsel_q :
      (avs_address == dpdc_pkg::REG_STEP_LO) ? step_q[31:0] :
      (avs_address == dpdc_pkg::REG_STEP_HI) ? {24'h00_0000, step_q[39:32]} :
      (avs_address == dpdc_pkg::REG_DEN24_0) ? {8'h00, den0_q} :
      (avs_address == dpdc_pkg::REG_DEN24_1) ? {8'h00, den1_q} :
      (avs_address == dpdc_pkg::REG_STATUS)  ? status_w :                   // R24
      (avs_address == dpdc_pkg::REG_NUM0_LO) ? num_q[0][31:0] :
      (avs_address == dpdc_pkg::REG_NUM0_HI) ? {24'h00_0000, num_q[0][39:32]} :
      (avs_address == dpdc_pkg::REG_NUM1_LO) ? num_q[1][31:0] :
      (avs_address == dpdc_pkg::REG_NUM1_HI) ? {24'h00_0000, num_q[1][39:32]} :
      (avs_address == dpdc_pkg::REG_GAIN)    ? {28'h000_0000, gain_q} : 32'h0000_0000;

   // Read data registered at the first edge of the access, before the answer; unmapped reads give zero
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && !ack_q) begin
         avs_readdata <= rmux_w;
      end
   end
endmodule

// ==== verif/dpdc_ctrl_checker.sv ====
// Checker: bus timing and register-to-pin relations of the dual loop control
`timescale 1ns/1ps
module dpdc_ctrl_checker #(
   parameter int REF_VALID_CYCLES = dpdc_pkg::REF_VALID_CYC
) (
   input wire logic        ref_clk,
   input wire logic        rst_b,
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic [1:0]  ref_lost,
   input wire logic [1:0]  aloop_locked_in,
   input wire logic [31:0] phase_err0,
   input wire logic [31:0] phase_err1,
   input wire logic [39:0] analog_num0,
   input wire logic [39:0] analog_num1,
   input wire logic [1:0]  den_fixed_sel,
   input wire logic [1:0]  aloop_ref_casc,
   input wire logic [1:0]  dloop_ref_casc,
   input wire logic [1:0]  dloop_ref_index,
   input wire logic        postdiv_bypass
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // Accepted accesses and those that may legally move a numerator
   wire        req    = avs_read || avs_write;
   wire        wr_ok  = avs_write && !avs_waitrequest;
   wire        ctl_wr = wr_ok && avs_address == dpdc_pkg::REG_CTRL;
   wire        num_wr = ctl_wr || (wr_ok && avs_address == dpdc_pkg::REG_DCO_CMD)
                        || (wr_ok && avs_address[7:4] == 4'h2);
   wire        rs_wr  = wr_ok && avs_address == dpdc_pkg::REG_REFSEL;
   // Written fields, checked at the pins two edges after acceptance
   wire [1:0]  wd_mode = avs_writedata[dpdc_pkg::CTRL_MODE1:dpdc_pkg::CTRL_MODE0];
   wire [3:0]  wd_pdiv = avs_writedata[dpdc_pkg::CTRL_POSTDIV +: 4];
   wire [2:0]  wd_casc = {avs_writedata[dpdc_pkg::RS_STRIDE], avs_writedata[2],
                          avs_writedata[0]};
   logic [3:0] quiet_q;
   logic       dig0_q;
   // Quiet time after steering writes; DCO pulse latency must fit inside it
   always_ff @(posedge ref_clk) begin
      if (!rst_b || num_wr) begin
         quiet_q <= 4'h0;
      end else if (quiet_q != 4'hF) begin
         quiet_q <= quiet_q + 4'h1;
      end
      dig0_q <= rst_b && (ctl_wr ? avs_writedata[dpdc_pkg::CTRL_DEN0] : dig0_q);
   end
   property p_wait_first;
      req && !$past(req) |-> avs_waitrequest;
   endproperty
   property p_wait_ans;
      req && avs_waitrequest |=> !avs_waitrequest;
   endproperty
   property p_unmapped;
      avs_read && !avs_waitrequest && avs_address == 8'hFC |=> avs_readdata == 32'h0;
   endproperty
   property p_center;
      $rose(rst_b) |-> analog_num0 == dpdc_pkg::CENTER_NUM && analog_num1 == dpdc_pkg::CENTER_NUM;
   endproperty
   property p_num_hold;
      quiet_q == 4'hF && !dig0_q |=> $stable(analog_num0);
   endproperty
   property p_den;
      $past(ctl_wr, 2) |-> den_fixed_sel == $past(wd_mode, 2);
   endproperty
   property p_postdiv;
      $past(ctl_wr, 2) |-> postdiv_bypass == ($past(wd_pdiv, 2) == 4'h1);
   endproperty
   property p_refsel;
      $past(rs_wr, 2) |-> {dloop_ref_casc, aloop_ref_casc[0]} == $past(wd_casc, 2);
   endproperty
   a_wait_first: assert property (p_wait_first) else $error("no wait on new request");
   a_wait_ans: assert property (p_wait_ans) else $error("answer late");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_center: assert property (p_center) else $error("numerator not centred");
   a_num_hold: assert property (p_num_hold) else $error("numerator moved");
   a_den: assert property (p_den) else $error("denominator select wrong");
   a_postdiv: assert property (p_postdiv) else $error("bypass wrong");
   a_refsel: assert property (p_refsel) else $error("reference select wrong");
   c_dco: cover property (wr_ok && avs_address == dpdc_pkg::REG_DCO_CMD);
   c_stat: cover property (avs_read && !avs_waitrequest && avs_address == dpdc_pkg::REG_STATUS);
   c_byp: cover property (postdiv_bypass);
endmodule
bind dpdc_ctrl dpdc_ctrl_checker #(.REF_VALID_CYCLES(REF_VALID_CYCLES)) u_chk (
   .ref_clk(ref_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ref_lost(ref_lost),
   .aloop_locked_in(aloop_locked_in), .phase_err0(phase_err0), .phase_err1(phase_err1),
   .analog_num0(analog_num0), .analog_num1(analog_num1), .den_fixed_sel(den_fixed_sel),
   .aloop_ref_casc(aloop_ref_casc), .dloop_ref_casc(dloop_ref_casc),
   .dloop_ref_index(dloop_ref_index), .postdiv_bypass(postdiv_bypass));

// ==== verif/dpdc_ref_model.sv ====
// Model: reference inputs, their monitors and crystal-locked analog loops
`timescale 1ns/1ps
module dpdc_ref_model #(
   parameter int LOCK_CYC = 40
) (
   input  wire logic        ref_clk,
   input  wire logic        rst_b,
   input  wire logic [1:0]  lose_ref,
   output logic [1:0]       ref_lost,
   output logic [1:0]       aloop_locked_in,
   output logic [31:0]      phase_err0,
   output logic [31:0]      phase_err1
);
   logic [7:0] lock_cnt_q;
   // Loops settle on the crystal after reset; a dead input gives a toggling word
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         lock_cnt_q <= 8'h00;
         phase_err0 <= 32'h0;
         phase_err1 <= 32'h0;
      end else begin
         lock_cnt_q <= lock_cnt_q + 8'(lock_cnt_q != 8'(LOCK_CYC));
         phase_err0 <= lose_ref[0] ? ~phase_err0 : 32'h0000_0040;
         phase_err1 <= lose_ref[1] ? ~phase_err1 : 32'h0000_0020;
      end
      ref_lost <= lose_ref;
   end
   assign aloop_locked_in = {2{lock_cnt_q == 8'(LOCK_CYC)}};
endmodule

// ==== verif/tb_dpdc_ctrl.sv ====
// Testbench: register-level scenarios for the dual loop domain control
`timescale 1ns/1ps
module tb_dpdc_ctrl;
   logic        ref_clk, rst_b, avs_read, avs_write, avs_waitrequest, postdiv_bypass;
   logic [7:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, phase_err0, phase_err1, rd;
   logic [1:0]  ref_lost, aloop_locked_in, den_fixed_sel, aloop_ref_casc, dloop_ref_casc;
   logic [1:0]  dloop_ref_index, lose_ref;
   logic [39:0] analog_num0, analog_num1;
   int          n_mismatch, comparisons, i;
   localparam logic [39:0] CTR = dpdc_pkg::CENTER_NUM;
   dpdc_ctrl #(.REF_VALID_CYCLES(4)) DUT (.ref_clk(ref_clk), .rst_b(rst_b),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .ref_lost(ref_lost), .aloop_locked_in(aloop_locked_in),
      .phase_err0(phase_err0), .phase_err1(phase_err1), .analog_num0(analog_num0),
      .analog_num1(analog_num1), .den_fixed_sel(den_fixed_sel), .aloop_ref_casc(aloop_ref_casc),
      .dloop_ref_casc(dloop_ref_casc), .dloop_ref_index(dloop_ref_index),
      .postdiv_bypass(postdiv_bypass));
   dpdc_ref_model u_src (.ref_clk(ref_clk), .rst_b(rst_b), .lose_ref(lose_ref),
      .ref_lost(ref_lost), .aloop_locked_in(aloop_locked_in), .phase_err0(phase_err0),
      .phase_err1(phase_err1));
   // 100 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   // One Avalon access, held until waitrequest is sampled low; idle cycle after
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0) begin
         n++;
         if (n > 20) begin
            n_mismatch++;
            give_verdict();
         end
         @(posedge ref_clk);
      end
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge ref_clk);
   endtask
   // Status polled under a bound; running out ends the run
   task automatic poll(input string nm, input logic [31:0] m, input logic [31:0] v);
      int n;
      for (n = 0; n < 300 && (n == 0 || (rd & m) !== v); n++) bus(1'b0, dpdc_pkg::REG_STATUS, 0);
      chk(nm, 40'(v), 40'(rd & m));
      if ((rd & m) !== v) give_verdict();
   endtask
   task automatic wait_num(input string nm, input logic [39:0] e);
      int n;
      for (n = 0; n < 50 && analog_num0 !== e; n++) @(posedge ref_clk);
      chk(nm, e, analog_num0);
   endtask
   initial begin
      rst_b = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 8'h00;
      avs_writedata = 32'h0;
      lose_ref = 2'b00;
      n_mismatch = 0;
      comparisons = 0;
      repeat (16) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      chk("den_fixed_sel", 40'h3, 40'(den_fixed_sel));
      chk("analog_num0", CTR, analog_num0);
      bus(1'b0, dpdc_pkg::REG_CTRL, 0);
      chk("ctrl", 40'h33, 40'(rd));
      bus(1'b0, 8'hFC, 0);
      chk("unmapped", 40'h0, 40'(rd));
      $display("test reset done");
      // Every denominator mode, then post-divider values around one
      for (i = 0; i < 4; i++) begin
         bus(1'b1, dpdc_pkg::REG_CTRL, 32'h3 | 32'(i << 4));
         chk("den_fixed_sel", 40'(i), 40'(den_fixed_sel));
      end
      for (i = 0; i < 3; i++) begin
         bus(1'b1, dpdc_pkg::REG_CTRL, 32'h33 | 32'(i << 10));
         chk("postdiv_bypass", 40'(i == 1), 40'(postdiv_bypass));
      end
      // Cascade on different pairs only, never both references of one pair
      bus(1'b1, dpdc_pkg::REG_REFSEL, 32'h11);
      chk("aloop_ref_casc0", 40'h1, 40'(aloop_ref_casc[0]));
      chk("dloop_ref_casc", 40'h2, 40'(dloop_ref_casc));
      bus(1'b1, dpdc_pkg::REG_REFSEL, 32'h4);
      chk("dloop_ref_casc", 40'h1, 40'(dloop_ref_casc));
      bus(1'b1, dpdc_pkg::REG_REFSEL, 32'h0);
      $display("test selects done");
      poll("analog lock", 32'h3, 32'h3);
      // Stepping with digital loops off and 24-bit denominators
      bus(1'b1, dpdc_pkg::REG_CTRL, 32'h43);
      bus(1'b1, dpdc_pkg::REG_STEP_LO, 32'h10);
      bus(1'b1, dpdc_pkg::REG_STEP_HI, 32'h1);
      bus(1'b1, dpdc_pkg::REG_DCO_CMD, 32'h1);
      wait_num("num0 up", CTR + 40'h1_0000_0010);
      bus(1'b1, dpdc_pkg::REG_DCO_CMD, 32'h2);
      wait_num("num0 down", CTR);
      chk("analog_num1", CTR, analog_num1);
      $display("test stepping done");
      // Lock flags, then acquisition only on a valid reference; loop gain untouched
      // Start order: the loop named by the priority bit calibrates first
      for (i = 0; i < 2; i++) begin
         bus(1'b1, dpdc_pkg::REG_CTRL, 32'h30);
         bus(1'b1, dpdc_pkg::REG_CTRL, 32'h33 | 32'(i << 8));
         bus(1'b0, dpdc_pkg::REG_STATUS, 0);
         chk("start order", (i == 0) ? 40'h10 : 40'h40, 40'(rd & 32'hF0));
      end
      lose_ref <= 2'b11;
      bus(1'b1, dpdc_pkg::REG_CTRL, 32'h217);
      repeat (50) @(posedge ref_clk);
      poll("no lock", 32'h4, 32'h0);
      lose_ref <= 2'b00;
      poll("digital lock", 32'hC, 32'h4);
      chk("num0 steered", 40'h1, 40'(analog_num0 !== CTR));
      chk("num1 follows", 40'h1, 40'(analog_num1 !== CTR));
      lose_ref <= 2'b01;
      repeat (8) @(posedge ref_clk);
      chk("dloop_ref_index", 40'h1, 40'(dloop_ref_index[0]));
      poll("hitless", 32'h4, 32'h4);
      lose_ref <= 2'b11;
      poll("holdover", 32'h4, 32'h0);
      $display("test acquisition done");
      give_verdict();
   end
endmodule
